/* File: rtl/igc_pkg.sv */
/*
  Shared constants and carrier types of the interrupt global control
  block: register offsets, field positions, reset values, event layout.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package igc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_ALU_FLAGS = 8'h00;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h04;
  localparam logic [7:0] OFF_GCTRL_A   = 8'h08;
  localparam logic [7:0] OFF_GCTRL_B   = 8'h0C;
  localparam logic [7:0] OFF_EVT_STAT  = 8'h10;
  localparam logic [7:0] OFF_EVT_MASK  = 8'h14;

  // Field positions
  localparam int ALU_PRIO_LSB   = 5;
  localparam int ALU_PRIO_MSB   = 7;
  localparam int CORE_TOP_BIT   = 3;
  localparam int CORE_PSV_BIT   = 2;
  localparam int A_NEST_BIT     = 15;
  localparam int A_ARITH_BIT    = 4;
  localparam int A_ADDR_BIT     = 3;
  localparam int A_STACK_BIT    = 2;
  localparam int A_OSC_BIT      = 1;
  localparam int B_ALT_BIT      = 15;
  localparam int B_DEFER_BIT    = 14;
  localparam int B_POL_LSB      = 0;
  localparam int EXT_IRQS       = 3;
  localparam int EVT_EXT_LSB    = 0;
  localparam int EVT_TRAP_LSB   = 3;
  localparam int EVT_BITS       = 7;

  // Level at or above which user interrupts are all blocked
  localparam logic [3:0] PRIO_USER_MAX = 4'h7;

  // Reset values
  localparam logic [2:0] RST_PRIO_LOW = 3'h0;
  localparam logic       RST_BIT      = 1'b0;
  localparam logic [3:0] RST_TRAPS    = 4'h0;
  localparam logic [2:0] RST_POL      = 3'h0;
  localparam logic [6:0] RST_EVT      = 7'h00;

  typedef struct packed {
    logic arith;
    logic addr;
    logic stack;
    logic osc;
  } igc_trap_t;

  typedef struct packed {
    logic       load;
    logic [3:0] level;
  } igc_prio_t;

endpackage

/* File: rtl/igc_edge_det.sv */
/*
  Edge detectors for the external interrupt pins, one per pin, with a
  per-pin polarity select. Assumes pins already synchronous to CLK.
*/
`timescale 1ns/1ps
module igc_edge_det #(
  parameter int N = 3
) (
  input  wire logic         CLK,   // System clock
  input  wire logic         RSTN,  // Sync reset, active low
  input  wire logic [N-1:0] PIN,   // External interrupt pins
  input  wire logic [N-1:0] POL,   // 1 falling, 0 rising
  output logic      [N-1:0] REQ    // One-cycle request pulses
);

  logic [N-1:0] cur;
  logic [N-1:0] prev;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cur  <= '0;
      prev <= '0;
    end else begin
      cur  <= PIN;
      prev <= cur;
    end
  end

  // Pulse lasts exactly the one cycle in which cur and prev differ
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_det
      assign REQ[g] = POL[g] ? (prev[g] & ~cur[g])
                             : (~prev[g] & cur[g]);
    end
  endgenerate

endmodule

/* File: rtl/igc_top.sv */
/*
  Interrupt global control: CPU priority level, nesting control, trap
  status flags, vector table select, deferral status, external pin
  edge polarity, and an event status/mask pair driving one IRQ line.
  Assumes an APB master on CLK and a core that reports traps as
  one-cycle pulses and priority changes through a load strobe.
*/
`timescale 1ns/1ps
module igc_top
  import igc_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic              CLK,         // 250 MHz system clock
  input  wire logic              RSTN,        // Sync reset, active low
  input  wire logic              PSEL,        // APB select
  input  wire logic              PENABLE,     // APB access phase
  input  wire logic              PWRITE,      // APB write
  input  wire logic [AW-1:0]     PADDR,       // APB byte address
  input  wire logic [31:0]       PWDATA,      // APB write data
  input  wire logic [3:0]        PSTRB,       // APB byte strobes
  output logic      [31:0]       PRDATA,      // APB read data
  output logic                   PREADY,      // APB ready
  output logic                   PSLVERR,     // APB error
  input  wire igc_pkg::igc_trap_t TRAP,       // Trap pulses from core
  input  wire igc_pkg::igc_prio_t PRIO_SET,   // Core priority update
  input  wire logic              DEFER_ACTIVE, // Deferral in effect
  input  wire logic [2:0]        EXT_IRQ,     // External interrupt pins
  output logic      [3:0]        CPU_PRIO,    // CPU priority level
  output logic                   USER_BLOCK,  // User requests blocked
  output logic                   NEST_DIS,    // Nesting disabled
  output logic                   ALT_VEC,     // Alternate table in use
  output logic      [2:0]        EXT_REQ,     // Edge request pulses
  output logic                   IRQ          // Level interrupt
);
  import igc_pkg::*;

  logic            cpu_priority_top_bit;
  logic [2:0]      cpu_priority_low_bits;
  logic            psv;
  logic            nesting_disable;
  igc_trap_t       trap_flags;
  logic            alt_vector_table_select;
  logic [2:0]      ext_irq_edge_polarity;
  logic [6:0]      evt_stat;
  logic [6:0]      evt_mask;
  logic [2:0]      ext_req;
  logic            wr_en;
  logic            rd_setup;
  logic [15:0]     wd;
  logic [31:0]     next_rdata;
  logic            next_err;
  logic [6:0]      evt_now;
  logic [3:0]      trap_vec;

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0]    off);
    return a == AW'(off);
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return hit(a, OFF_ALU_FLAGS) | hit(a, OFF_CORE_CTRL) |
           hit(a, OFF_GCTRL_A)   | hit(a, OFF_GCTRL_B)   |
           hit(a, OFF_EVT_STAT)  | hit(a, OFF_EVT_MASK);
  endfunction

  // Zero-wait slave; write lands at the access edge
  assign PREADY   = 1'b1;
  assign wr_en    = PSEL & PENABLE & PWRITE & mapped(PADDR);
  assign rd_setup = PSEL & ~PENABLE;
  // Only the two low byte lanes carry register bits
  assign wd       = {PSTRB[1] ? PWDATA[15:8] : 8'h00,
                     PSTRB[0] ? PWDATA[7:0]  : 8'h00};

  // CPU priority level
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cpu_priority_low_bits <= RST_PRIO_LOW;
    end else if (PRIO_SET.load) begin
      cpu_priority_low_bits <= PRIO_SET.level[2:0];
    end else if (wr_en && hit(PADDR, OFF_ALU_FLAGS) && PSTRB[0]
                 && !nesting_disable) begin
      cpu_priority_low_bits <= wd[ALU_PRIO_MSB:ALU_PRIO_LSB];
    end
  end

  // Top bit follows hardware only; software may clear, never set
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cpu_priority_top_bit <= RST_BIT;
    end else if (PRIO_SET.load) begin
      cpu_priority_top_bit <= PRIO_SET.level[3];
    end else if (wr_en && hit(PADDR, OFF_CORE_CTRL) && PSTRB[0]
                 && !wd[CORE_TOP_BIT]) begin
      cpu_priority_top_bit <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      psv <= RST_BIT;
    end else if (wr_en && hit(PADDR, OFF_CORE_CTRL) && PSTRB[0]) begin
      psv <= wd[CORE_PSV_BIT];
    end
  end

  assign CPU_PRIO   = {cpu_priority_top_bit,
                       cpu_priority_low_bits};
  assign USER_BLOCK = CPU_PRIO >= PRIO_USER_MAX;

  // Control A: nesting disable
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      nesting_disable <= RST_BIT;
    end else if (wr_en && hit(PADDR, OFF_GCTRL_A) && PSTRB[1]) begin
      nesting_disable <= wd[A_NEST_BIT];
    end
  end

  // Trap flags: software writes both ways, a trap pulse always wins
  assign trap_vec = TRAP;
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      trap_flags <= RST_TRAPS;
    end else begin
      if (wr_en && hit(PADDR, OFF_GCTRL_A) && PSTRB[0]) begin
        trap_flags <= wd[A_ARITH_BIT:A_OSC_BIT] | trap_vec;
      end else begin
        trap_flags <= trap_flags | trap_vec;
      end
    end
  end

  // Control B: vector table select and pin polarities
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      alt_vector_table_select <= RST_BIT;
    end else if (wr_en && hit(PADDR, OFF_GCTRL_B) && PSTRB[1]) begin
      alt_vector_table_select <= wd[B_ALT_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ext_irq_edge_polarity <= RST_POL;
    end else if (wr_en && hit(PADDR, OFF_GCTRL_B) && PSTRB[0]) begin
      ext_irq_edge_polarity <= wd[B_POL_LSB+2:B_POL_LSB];
    end
  end

  assign NEST_DIS = nesting_disable;
  assign ALT_VEC  = alt_vector_table_select;

  igc_edge_det #(
    .N (EXT_IRQS)
  ) u_edge (
    .CLK  (CLK),
    .RSTN (RSTN),
    .PIN  (EXT_IRQ),
    .POL  (ext_irq_edge_polarity),
    .REQ  (ext_req)
  );
  assign EXT_REQ = ext_req;

  // Event status, write one to clear; a new event wins over the clear
  assign evt_now = {trap_vec, ext_req};
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      evt_stat <= RST_EVT;
    end else if (wr_en && hit(PADDR, OFF_EVT_STAT) && PSTRB[0]) begin
      evt_stat <= (evt_stat & ~wd[6:0]) | evt_now;
    end else begin
      evt_stat <= evt_stat | evt_now;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      evt_mask <= RST_EVT;
    end else if (wr_en && hit(PADDR, OFF_EVT_MASK) && PSTRB[0]) begin
      evt_mask <= wd[6:0];
    end
  end

  assign IRQ = |(evt_stat & evt_mask);

  // Read data captured in the setup cycle, shown in the access cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = ~mapped(PADDR);
    if (hit(PADDR, OFF_ALU_FLAGS)) begin
      next_rdata[ALU_PRIO_MSB:ALU_PRIO_LSB] = cpu_priority_low_bits;
    end
    if (hit(PADDR, OFF_CORE_CTRL)) begin
      next_rdata[CORE_TOP_BIT] = cpu_priority_top_bit;
      next_rdata[CORE_PSV_BIT] = psv; // bits 1:0 stay zero
    end
    if (hit(PADDR, OFF_GCTRL_A)) begin
      next_rdata[A_NEST_BIT]             = nesting_disable;
      next_rdata[A_ARITH_BIT:A_OSC_BIT]  = trap_flags;
    end
    if (hit(PADDR, OFF_GCTRL_B)) begin
      next_rdata[B_ALT_BIT]   = alt_vector_table_select;
      next_rdata[B_DEFER_BIT] = DEFER_ACTIVE;
      next_rdata[B_POL_LSB+2:B_POL_LSB] = ext_irq_edge_polarity;
    end // bits 13:3 stay zero
    if (hit(PADDR, OFF_EVT_STAT)) begin
      next_rdata[6:0] = evt_stat;
    end
    if (hit(PADDR, OFF_EVT_MASK)) begin
      next_rdata[6:0] = evt_mask;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (rd_setup) begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : next_rdata;
      PSLVERR <= next_err;
    end
  end

  // Checks
  sequence s_rd_setup(logic [7:0] off);
    PSEL && !PENABLE && !PWRITE && hit(PADDR, off);
  endsequence

  sequence s_wr_access(logic [7:0] off);
    PSEL && PENABLE && PWRITE && hit(PADDR, off);
  endsequence

  property p_prio_load;
    @(posedge CLK) disable iff (!RSTN)
    PRIO_SET.load |=> CPU_PRIO == $past(PRIO_SET.level)
                      && (CPU_PRIO[3] == (CPU_PRIO > 4'h7));
  endproperty
  a_prio_load: assert property (p_prio_load)
    else $error("priority level not loaded from core");

  property p_core_rsvd;
    @(posedge CLK) disable iff (!RSTN)
    s_rd_setup(OFF_CORE_CTRL) |=> PRDATA[1:0] == 2'h0;
  endproperty
  a_core_rsvd: assert property (p_core_rsvd)
    else $error("core control low bits not zero");

  property p_nest_wr;
    @(posedge CLK) disable iff (!RSTN)
    s_wr_access(OFF_GCTRL_A) and PSTRB[1]
      |=> NEST_DIS == $past(PWDATA[A_NEST_BIT]);
  endproperty
  a_nest_wr: assert property (p_nest_wr)
    else $error("nesting disable did not take write");

  property p_trap_set;
    @(posedge CLK) disable iff (!RSTN)
    TRAP.arith |=> trap_flags.arith ##0 evt_stat[EVT_TRAP_LSB+3];
  endproperty
  a_trap_set: assert property (p_trap_set)
    else $error("arith trap did not set flags");

  property p_alt_wr;
    @(posedge CLK) disable iff (!RSTN)
    s_wr_access(OFF_GCTRL_B) and PSTRB[1]
      |=> ALT_VEC == $past(PWDATA[B_ALT_BIT]);
  endproperty
  a_alt_wr: assert property (p_alt_wr)
    else $error("vector table select did not take write");

  property p_defer_rd;
    @(posedge CLK) disable iff (!RSTN)
    s_rd_setup(OFF_GCTRL_B) |=> PRDATA[B_DEFER_BIT] == $past(DEFER_ACTIVE)
                                && PRDATA[13:3] == 11'h000;
  endproperty
  a_defer_rd: assert property (p_defer_rd)
    else $error("control B read value wrong");

  genvar gi;
  generate
    for (gi = 0; gi < EXT_IRQS; gi++) begin : g_chk
      property p_ext_edge;
        @(posedge CLK) disable iff (!RSTN)
        ($rose(EXT_IRQ[gi]) && !ext_irq_edge_polarity[gi]) ||
        ($fell(EXT_IRQ[gi]) && ext_irq_edge_polarity[gi])
          |=> EXT_REQ[gi] ##1 !EXT_REQ[gi];
      endproperty
      a_ext_edge: assert property (p_ext_edge)
        else $error("edge request missing or too long");
    end
  endgenerate

  property p_top_no_set;
    @(posedge CLK) disable iff (!RSTN)
    !cpu_priority_top_bit && !PRIO_SET.load |=> !cpu_priority_top_bit;
  endproperty
  a_top_no_set: assert property (p_top_no_set)
    else $error("top priority bit set without hardware");

  property p_low_ro;
    @(posedge CLK) disable iff (!RSTN)
    nesting_disable && !PRIO_SET.load |=> $stable(cpu_priority_low_bits);
  endproperty
  a_low_ro: assert property (p_low_ro)
    else $error("low priority bits changed while nesting disabled");

  property p_block;
    @(posedge CLK) disable iff (!RSTN)
    CPU_PRIO == 4'h7 |-> USER_BLOCK;
  endproperty
  a_block: assert property (p_block)
    else $error("level 7 did not block user requests");

  property p_set_wins;
    @(posedge CLK) disable iff (!RSTN)
    s_wr_access(OFF_GCTRL_A) and (TRAP.stack && PSTRB[0])
      |=> trap_flags.stack;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("trap clear beat a trap set");

endmodule

/* File: testbench/igc_core_model.sv */
/*
  Behavioural model of the processor core and the three external
  interrupt pins: trap pulses, priority loads, deferral level, pins.
  Assumes the bench calls its tasks; all outputs change after CLK rises.
*/
`timescale 1ns/1ps
module igc_core_model
  import igc_pkg::*;
(
  input  wire logic         CLK,          // System clock
  output igc_pkg::igc_trap_t TRAP,        // Trap pulses to controller
  output igc_pkg::igc_prio_t PRIO_SET,    // Level load from core
  output logic              DEFER_ACTIVE, // Deferral in effect
  output logic [2:0]        EXT_IRQ       // External pins
);
  import igc_pkg::*;

  initial begin
    TRAP = '0;
    PRIO_SET = '0;
    DEFER_ACTIVE = 1'b0;
    EXT_IRQ = 3'h0;
  end

  // Traps come as single-cycle pulses, never held
  task automatic trap_pulse(input igc_trap_t t);
    @(posedge CLK);
    TRAP <= t;
    @(posedge CLK);
    TRAP <= '0;
  endtask

  task automatic load_level(input logic [3:0] lv);
    @(posedge CLK);
    PRIO_SET <= '{load: 1'b1, level: lv};
    @(posedge CLK);
    PRIO_SET <= '0;
  endtask

  task automatic set_pin(input int i, input logic v);
    @(posedge CLK);
    EXT_IRQ[i] <= v;
  endtask

  task automatic set_defer(input logic v);
    @(posedge CLK);
    DEFER_ACTIVE <= v;
  endtask
endmodule

/* File: testbench/igc_top_bench.sv */
/*
  Self-checking bench for the interrupt global control block: APB
  read and write tasks and call sequences with expected values.
  Assumes the core model beside it drives traps, levels and pins.
*/
`timescale 1ns/1ps
module igc_top_bench;
  import igc_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, cpu_prio;
  logic        pready, pslverr, user_block, nest_dis, alt_vec, irq;
  logic [2:0]  ext_req, ext_irq;
  logic        defer;
  igc_trap_t   trap;
  igc_prio_t   prio_set;
  int          bad_count, num_checks;

  igc_top igc_top_i (.CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TRAP(trap), .PRIO_SET(prio_set), .DEFER_ACTIVE(defer),
    .EXT_IRQ(ext_irq), .CPU_PRIO(cpu_prio), .USER_BLOCK(user_block),
    .NEST_DIS(nest_dis), .ALT_VEC(alt_vec), .EXT_REQ(ext_req), .IRQ(irq));
  igc_core_model igc_core_model_i (.CLK(clk), .TRAP(trap),
    .PRIO_SET(prio_set), .DEFER_ACTIVE(defer), .EXT_IRQ(ext_irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Waits on PREADY under a bound even though the slave never stalls
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the access edge's register updates settle before any compare
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // One pin change, then the request pulse and its end
  task automatic pin_step(input int i, input logic v, input logic hit);
    igc_core_model_i.set_pin(i, v);
    @(posedge clk);
    #1;
    check(32'(ext_req), hit ? 32'(3'b001 << i) : 32'h0000_0000);
    @(posedge clk);
    #1;
    check(32'(ext_req), 32'h0000_0000);
  endtask

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    bad_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 6; k++) rdchk(8'(4 * k), 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    wr(OFF_ALU_FLAGS, 32'h0000_00FF);
    rdchk(OFF_ALU_FLAGS, 32'h0000_00E0);
    check(32'(user_block), 32'h0000_0001);
    wr(OFF_CORE_CTRL, 32'h0000_000F);
    rdchk(OFF_CORE_CTRL, 32'h0000_0004);
    check(32'(cpu_prio), 32'h0000_0007);
    igc_core_model_i.load_level(4'hA);
    #1;
    check(32'(cpu_prio), 32'h0000_000A);
    rdchk(OFF_CORE_CTRL, 32'h0000_000C);
    rdchk(OFF_ALU_FLAGS, 32'h0000_0040);
    igc_core_model_i.load_level(4'h6);
    rdchk(OFF_CORE_CTRL, 32'h0000_0004);
    check(32'(user_block), 32'h0000_0000);
    wr(OFF_GCTRL_A, 32'h0000_8000);
    check(32'(nest_dis), 32'h0000_0001);
    wr(OFF_ALU_FLAGS, 32'h0000_0020);
    rdchk(OFF_ALU_FLAGS, 32'h0000_00C0);
    wr(OFF_GCTRL_A, 32'h0000_0000);
    wr(OFF_ALU_FLAGS, 32'h0000_0020);
    rdchk(OFF_ALU_FLAGS, 32'h0000_0020);
    for (int i = 0; i < 4; i++) begin
      igc_core_model_i.trap_pulse(igc_trap_t'(4'b0001 << i));
      rdchk(OFF_GCTRL_A, 32'(5'b00010 << i));
      wr(OFF_GCTRL_A, 32'h0000_0000);
    end
    rdchk(OFF_EVT_STAT, 32'h0000_0078);
    check(32'(irq), 32'h0000_0000);
    wr(OFF_EVT_MASK, 32'h0000_0040);
    check(32'(irq), 32'h0000_0001);
    wr(OFF_EVT_STAT, 32'h0000_0040);
    check(32'(irq), 32'h0000_0000);
    rdchk(OFF_EVT_STAT, 32'h0000_0038);
    // Clear lands on the same edge as a new stack trap
    igc_core_model_i.trap_pulse('{arith: 1'b1, default: 1'b0});
    fork
      wr(OFF_GCTRL_A, 32'h0000_0000);
      begin
        @(posedge clk);
        igc_core_model_i.trap_pulse('{stack: 1'b1, default: 1'b0});
      end
    join
    rdchk(OFF_GCTRL_A, 32'h0000_0004);
    wr(OFF_GCTRL_B, 32'h0000_FFFF);
    rdchk(OFF_GCTRL_B, 32'h0000_8007);
    check(32'(alt_vec), 32'h0000_0001);
    igc_core_model_i.set_defer(1'b1);
    rdchk(OFF_GCTRL_B, 32'h0000_C007);
    igc_core_model_i.set_defer(1'b0);
    wr(OFF_EVT_STAT, 32'h0000_007F);
    for (int p = 0; p < 2; p++) begin
      wr(OFF_GCTRL_B, p ? 32'h0000_0007 : 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
        pin_step(i, 1'b1, p == 0);
        pin_step(i, 1'b0, p == 1);
      end
    end
    check(32'(alt_vec), 32'h0000_0000);
    rdchk(OFF_EVT_STAT, 32'h0000_0007);
    end_of_test();
  end
endmodule
